// file: src/cmd_hk_pkg.sv
// shared constants for the command and housekeeping link block
package cmd_hk_pkg;
    localparam int BYTE_W = 8;
    localparam int WORD_BYTES = 4;
    localparam int WORD_W = BYTE_W * WORD_BYTES;
    localparam int LINK_COUNT = 2;
    localparam int LINK_A = 0;
    localparam int LINK_B = 1;
    localparam int HK_FIFO_DEPTH = 16;
    localparam logic [1:0] LAST_BYTE_INDEX = 2'h3;
    localparam logic [2:0] LAST_BIT_INDEX = 3'h7;
    localparam logic [5:0] WORD_BIT_COUNT = 6'h20;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [31:0] WORD_RESET = 32'h00000000;
    typedef enum logic [0:0] {
        TX_IDLE,
        TX_SHIFT
    } tx_state_t;
endpackage

// file: src/command_housekeeping_link_regs.sv
// command receive registers and housekeeping transmit path for two links
`timescale 1ns/1ps
// What this block does
// - each link assembles every 32-bit command word it accepts into its own four byte registers.
// - loading the last byte register of a link's group raises a processor interrupt.
// - a link's busy line goes high as soon as the first bit of a new word arrives.
// - the processor reading the last byte register of a link that holds a complete word clears that link's busy.
// - links A and B are always active and each has an independent receive group.
// - a word is accepted on whichever link delivers it; bits arriving while that link still holds an unread word are dropped.
// - link A has the primary interrupt and link B the secondary one.
// - four byte transmit registers are shifted out serially by hardware alone.
// - the processor's 32-bit status word is taken from transmit registers 0 to 2 plus the last byte being written, as one unit.
// - every accepted status word goes out on both links at the same time.
module command_housekeeping_link_regs
    import cmd_hk_pkg::*;
#(
    parameter int FIFO_DEPTH = HK_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_en,
    input wire logic [LINK_COUNT-1:0] cmd_bit,
    input wire logic [LINK_COUNT-1:0] cmd_bit_valid,
    output logic [LINK_COUNT-1:0] cmd_busy,
    output logic irq_primary,
    output logic irq_secondary,
    input wire logic cpu_rd,
    input wire logic cpu_rd_link,
    input wire logic [1:0] cpu_rd_index,
    output logic [BYTE_W-1:0] cpu_rd_data,
    input wire logic cpu_wr,
    input wire logic [1:0] cpu_wr_index,
    input wire logic [BYTE_W-1:0] cpu_wr_data,
    output logic hk_wr_ready,
    output logic [LINK_COUNT-1:0] hk_tx_bit,
    output logic [LINK_COUNT-1:0] hk_tx_frame
);
    // refused at elaboration rather than left to misbehave in a run
    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("housekeeping fifo needs at least two words");
    end

    // receive side state, one group per link
    logic [BYTE_W-1:0] rx_reg [LINK_COUNT][WORD_BYTES];
    logic [BYTE_W-1:0] rx_shift [LINK_COUNT];
    logic [2:0] rx_bit_cnt [LINK_COUNT];
    logic [1:0] rx_byte_cnt [LINK_COUNT];
    logic [LINK_COUNT-1:0] rx_full;
    logic [LINK_COUNT-1:0] word_done;
    logic [LINK_COUNT-1:0] last_read;

    genvar gl;
    generate
        for (gl = 0; gl < LINK_COUNT; gl++) begin : g_link
            logic take_bit;
            logic [BYTE_W-1:0] next_byte;

            // bits offered while the word is still unread are dropped
            assign take_bit = cmd_bit_valid[gl] && !rx_full[gl];
            assign next_byte = {rx_shift[gl][BYTE_W-2:0], cmd_bit[gl]};
            assign word_done[gl] = take_bit && (rx_bit_cnt[gl] == LAST_BIT_INDEX)
                && (rx_byte_cnt[gl] == LAST_BYTE_INDEX);
            assign last_read[gl] = cpu_rd && (cpu_rd_link == 1'(gl))
                && (cpu_rd_index == LAST_BYTE_INDEX);

            // serial to byte assembly, msb first within each byte
            always_ff @(posedge clock) begin
                if (rst) begin
                    rx_shift[gl] <= BYTE_RESET;
                    rx_bit_cnt[gl] <= '0;
                    rx_byte_cnt[gl] <= '0;
                end else if (clock_en && take_bit) begin
                    rx_shift[gl] <= next_byte;
                    rx_bit_cnt[gl] <= rx_bit_cnt[gl] + 1'b1;
                    if (rx_bit_cnt[gl] == LAST_BIT_INDEX) begin
                        rx_byte_cnt[gl] <= rx_byte_cnt[gl] + 1'b1;
                    end
                end
            end

            // completed bytes land in arrival order
            always_ff @(posedge clock) begin
                if (rst) begin
                    for (int i = 0; i < WORD_BYTES; i++) begin
                        rx_reg[gl][i] <= BYTE_RESET;
                    end
                end else if (clock_en && take_bit && rx_bit_cnt[gl] == LAST_BIT_INDEX) begin
                    rx_reg[gl][rx_byte_cnt[gl]] <= next_byte;
                end
            end

            // word-held flag: set by the last byte, cleared by the last read
            always_ff @(posedge clock) begin
                if (rst) begin
                    rx_full[gl] <= 1'b0;
                end else if (clock_en) begin
                    if (word_done[gl]) begin
                        rx_full[gl] <= 1'b1;
                    end else if (last_read[gl]) begin
                        rx_full[gl] <= 1'b0;
                    end
                end
            end

            // busy rises on the first bit and holds until the word is consumed
            always_ff @(posedge clock) begin
                if (rst) begin
                    cmd_busy[gl] <= 1'b0;
                end else if (clock_en) begin
                    if (take_bit) begin
                        cmd_busy[gl] <= 1'b1;
                    end else if (rx_full[gl] && last_read[gl]) begin
                        cmd_busy[gl] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // separate interrupt lines tell the processor which group holds a word
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_primary <= 1'b0;
            irq_secondary <= 1'b0;
        end else if (clock_en) begin
            irq_primary <= word_done[LINK_A];
            irq_secondary <= word_done[LINK_B];
        end
    end

    // registered read port, data valid the cycle after the strobe
    always_ff @(posedge clock) begin
        if (rst) begin
            cpu_rd_data <= BYTE_RESET;
        end else if (clock_en && cpu_rd) begin
            cpu_rd_data <= rx_reg[cpu_rd_link][cpu_rd_index];
        end
    end

    // transmit staging: four byte registers, byte 0 sent first
    logic [BYTE_W-1:0] hk_reg [WORD_BYTES];
    logic [WORD_W-1:0] hk_word;
    logic hk_push;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [WORD_W-1:0] fifo_out_data;

    assign hk_word = {hk_reg[0], hk_reg[1], hk_reg[2], cpu_wr_data};
    // writing the last byte hands the whole word over; refused when full
    assign hk_push = cpu_wr && (cpu_wr_index == LAST_BYTE_INDEX);

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < WORD_BYTES; i++) begin
                hk_reg[i] <= BYTE_RESET;
            end
        end else if (clock_en && cpu_wr) begin
            hk_reg[cpu_wr_index] <= cpu_wr_data;
        end
    end

    // ready follows the fifo's registered full flag a cycle late and drops for a cycle after each accepted push, so the processor can pace
    always_ff @(posedge clock) begin
        if (rst) begin
            hk_wr_ready <= 1'b0;
        end else if (clock_en) begin
            hk_wr_ready <= fifo_in_ready && !(hk_push && hk_wr_ready);
        end
    end

    hk_word_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_hk_word_fifo (
        .clock(clock),
        .rst(rst),
        .clock_en(clock_en),
        .in_valid(hk_push && hk_wr_ready),
        .in_ready(fifo_in_ready),
        .in_data(hk_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // serialiser: one bit per enabled cycle, same bit on both links
    tx_state_t tx_state;
    logic [WORD_W-1:0] tx_shift;
    logic [5:0] tx_left;

    assign fifo_out_ready = (tx_state == TX_IDLE);

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_state <= TX_IDLE;
            tx_shift <= WORD_RESET;
            tx_left <= '0;
        end else if (clock_en) begin
            unique case (tx_state)
                TX_IDLE: begin
                    if (fifo_out_valid) begin
                        tx_shift <= fifo_out_data;
                        tx_left <= WORD_BIT_COUNT;
                        tx_state <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    tx_shift <= {tx_shift[WORD_W-2:0], 1'b0};
                    tx_left <= tx_left - 1'b1;
                    if (tx_left == 6'h01) begin
                        tx_state <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // outputs registered; frame marks each of the 32 bit slots
    always_ff @(posedge clock) begin
        if (rst) begin
            hk_tx_bit <= '0;
            hk_tx_frame <= '0;
        end else if (clock_en) begin
            if (tx_state == TX_SHIFT) begin
                hk_tx_bit <= {LINK_COUNT{tx_shift[WORD_W-1]}};
                hk_tx_frame <= {LINK_COUNT{1'b1}};
            end else begin
                hk_tx_bit <= '0;
                hk_tx_frame <= '0;
            end
        end
    end
endmodule

// file: src/hk_word_fifo.sv
// parameterised word fifo with valid/ready on both sides
`timescale 1ns/1ps
module hk_word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);

    // refused at elaboration: the pointer wrap only works for powers of two
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
    logic full;
    logic empty;
    logic push;
    logic pop;
    logic [PTR_W:0] next_count;

    assign push = in_valid && !full;
    assign pop = out_valid && out_ready;
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // storage has no reset, only the pointers, count and flags need one
    always_ff @(posedge clock) begin
        if (clock_en && push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // full and empty kept as flops so both readies come straight from state
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            full <= 1'b0;
            empty <= 1'b1;
        end else if (clock_en) begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= next_count;
            full <= (next_count == (PTR_W + 1)'(DEPTH));
            empty <= (next_count == '0);
        end
    end
endmodule

// file: tb/cmd_hk_checker.sv
// assertion checker for the command and housekeeping link block
`timescale 1ns/1ps
module cmd_hk_checker
    import cmd_hk_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_en,
    input wire logic [LINK_COUNT-1:0] cmd_bit_valid,
    input wire logic [LINK_COUNT-1:0] cmd_busy,
    input wire logic irq_primary,
    input wire logic irq_secondary,
    input wire logic cpu_rd,
    input wire logic cpu_rd_link,
    input wire logic [1:0] cpu_rd_index,
    input wire logic cpu_wr,
    input wire logic [1:0] cpu_wr_index,
    input wire logic hk_wr_ready,
    input wire logic [LINK_COUNT-1:0] hk_tx_bit,
    input wire logic [LINK_COUNT-1:0] hk_tx_frame
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic held;
    logic rd_last;
    logic [5:0] fcnt;
    assign rd_last = clock_en && cpu_rd && !cpu_rd_link && cpu_rd_index == LAST_BYTE_INDEX;
    // link A word held; set from the irq, so it lags the design by a cycle on purpose
    always_ff @(posedge clock) begin
        if (rst || rd_last)
            held <= 1'b0;
        else if (irq_primary)
            held <= 1'b1;
    end
    // counts frame slots of the current housekeeping word
    always_ff @(posedge clock) begin
        if (!hk_tx_frame[0])
            fcnt <= 6'h00;
        else if (clock_en)
            fcnt <= fcnt + 6'h01;
    end
    hk_mirror_a: assert property (hk_tx_frame[0] == hk_tx_frame[1] && hk_tx_bit[0] == hk_tx_bit[1])
        else $error("links differ");
    frame_len_a: assert property ($fell(hk_tx_frame[0]) |-> fcnt == WORD_BIT_COUNT)
        else $error("frame length wrong");
    ready_drop_a: assert property (clock_en && cpu_wr && cpu_wr_index == LAST_BYTE_INDEX
        && hk_wr_ready |=> !hk_wr_ready) else $error("ready kept after push");
    busy_set_a: assert property (clock_en && cmd_bit_valid[0] && !cmd_busy[0] |=> cmd_busy[0])
        else $error("busy not raised");
    busy_hold_a: assert property (cmd_busy[1] && !cpu_rd |=> cmd_busy[1])
        else $error("busy dropped without read");
    busy_clear_a: assert property (held && rd_last && !cmd_bit_valid[0] |=> !cmd_busy[0])
        else $error("busy not cleared");
    irq_pulse_a: assert property (irq_primary |=> !irq_primary)
        else $error("irq longer than a cycle");
    irq_cause_a: assert property (irq_primary |-> $past(cmd_bit_valid[0]))
        else $error("irq without last bit");
    irq_link_a: assert property (irq_primary |-> cmd_busy[0])
        else $error("primary irq on idle link");
    irq_b_link_a: assert property (irq_secondary |-> cmd_busy[1])
        else $error("secondary irq on idle link");
    cover property (irq_primary);
    cover property (irq_secondary);
    cover property ($fell(hk_tx_frame[0]));
    cover property (cpu_wr && cpu_wr_index == LAST_BYTE_INDEX && !hk_wr_ready);
endmodule

// file: tb/cmd_sender.sv
// commanding computer model for one link
`timescale 1ns/1ps
module cmd_sender (
    input wire logic clock,
    input wire logic busy,
    input wire logic go,
    input wire logic rude,
    input wire logic slow,
    input wire logic [31:0] word,
    output logic bit_out,
    output logic valid,
    output logic active
);
    initial begin
        bit_out = 1'b0;
        valid = 1'b0;
        active = 1'b0;
    end
    // waits for busy low unless told to misbehave; any time, msb first
    always begin
        @(negedge clock);
        if (go && (!busy || rude)) begin
            active = 1'b1;
            for (int i = 31; i >= 0; i--) begin
                bit_out = word[i];
                valid = 1'b1;
                @(negedge clock);
                if (slow) begin
                    valid = 1'b0;
                    bit_out = ~bit_out; // stale data is not left on the line
                    @(negedge clock);
                end
            end
            valid = 1'b0;
            bit_out = ~bit_out;
            active = 1'b0;
        end
    end
endmodule

// file: tb/command_housekeeping_link_regs_tb.sv
// self-checking bench for the command and housekeeping link block
`timescale 1ns/1ps
module command_housekeeping_link_regs_tb;
    import cmd_hk_pkg::*;
    logic clock = 0;
    logic rst = 1;
    logic clock_en = 1;
    wire [1:0] cmd_bit;
    wire [1:0] cmd_bit_valid;
    wire [1:0] act;
    logic [1:0] cmd_busy, hk_tx_bit, hk_tx_frame, go = 0, rude = 0, slow = 0;
    logic irq_primary, irq_secondary, hk_wr_ready, fr = 0, fr1 = 0;
    logic cpu_rd = 0, cpu_rd_link = 0, cpu_wr = 0;
    logic [1:0] cpu_rd_index = 0, cpu_wr_index = 0;
    logic [7:0] cpu_rd_data, cpu_wr_data = 0;
    logic [31:0] word [2] = '{32'h0, 32'h0};
    logic [31:0] sr = 0, sr1 = 0;
    logic [31:0] rxq [$], rxq1 [$];
    int n_errors = 0, checked = 0, cyc = 0, nirq [2] = '{0, 0};
    always #20 clock = ~clock;
    command_housekeeping_link_regs u_command_housekeeping_link_regs (.clock, .rst, .clock_en,
        .cmd_bit, .cmd_bit_valid, .cmd_busy, .irq_primary, .irq_secondary, .cpu_rd, .cpu_rd_link,
        .cpu_rd_index, .cpu_rd_data, .cpu_wr, .cpu_wr_index, .cpu_wr_data, .hk_wr_ready,
        .hk_tx_bit, .hk_tx_frame);
    cmd_sender u_send_a (.clock, .busy(cmd_busy[0]), .go(go[0]), .rude(rude[0]), .slow(slow[0]),
        .word(word[0]), .bit_out(cmd_bit[0]), .valid(cmd_bit_valid[0]), .active(act[0]));
    cmd_sender u_send_b (.clock, .busy(cmd_busy[1]), .go(go[1]), .rude(rude[1]), .slow(slow[1]),
        .word(word[1]), .bit_out(cmd_bit[1]), .valid(cmd_bit_valid[1]), .active(act[1]));
    // counts interrupts, collects housekeeping words of both links, cuts a hang short
    // sampled at the falling edge, where the registered outputs have settled
    always @(negedge clock) begin
        if (irq_primary === 1'b1)
            nirq[0]++;
        if (irq_secondary === 1'b1)
            nirq[1]++;
        if (hk_tx_frame[0] === 1'b1)
            sr = {sr[30:0], hk_tx_bit[0]};
        if (hk_tx_frame[1] === 1'b1)
            sr1 = {sr1[30:0], hk_tx_bit[1]};
        if (fr && hk_tx_frame[0] === 1'b0)
            rxq.push_back(sr);
        if (fr1 && hk_tx_frame[1] === 1'b0)
            rxq1.push_back(sr1);
        fr = hk_tx_frame[0];
        fr1 = hk_tx_frame[1];
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic close_out;
        $display("compares %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic start(input int l, input logic [31:0] w, input logic r);
        word[l] = w;
        rude[l] = r;
        go[l] = 1;
        for (int k = 0; k < 50 && act[l] !== 1'b1; k++)
            @(negedge clock);
        go[l] = 0;
    endtask
    task automatic finish(input int l);
        for (int k = 0; k < 100 && act[l] !== 1'b0; k++)
            @(negedge clock);
        rude[l] = 0;
        @(negedge clock);
    endtask
    task automatic rd_word(input logic l, input logic [31:0] exp);
        logic [31:0] w;
        cpu_rd = 1;
        cpu_rd_link = l;
        for (int i = 0; i < 4; i++) begin
            cpu_rd_index = i[1:0];
            @(negedge clock);
            w = {w[23:0], cpu_rd_data};
        end
        cpu_rd = 0;
        // let an edge pass so a following read raises the strobe afresh
        @(negedge clock);
        cmp(w, exp);
    endtask
    task automatic t_rx;
        start(0, 32'hA5C30F96, 0);
        repeat (3) @(negedge clock);
        cmp(cmd_busy, 2'h1);
        finish(0);
        cmp(nirq[0], 1);
        cmp(nirq[1], 0);
        rd_word(0, 32'hA5C30F96);
        cmp(cmd_busy, 2'h0);
        $display("t_rx done");
    endtask
    task automatic t_both;
        slow[1] = 1;
        start(0, 32'h0123ABCD, 0);
        start(1, 32'hFEDC5432, 0);
        finish(0);
        finish(1);
        cmp(cmd_busy, 2'h3);
        cmp(nirq[0], 2);
        cmp(nirq[1], 1);
        rd_word(1, 32'hFEDC5432);
        cmp(cmd_busy, 2'h1);
        rd_word(0, 32'h0123ABCD);
        cmp(cmd_busy, 2'h0);
        $display("t_both done");
    endtask
    task automatic t_refuse;
        start(0, 32'h80000001, 0);
        finish(0);
        start(0, 32'h7FFFFFFE, 1);
        finish(0);
        cmp(nirq[0], 3);
        rd_word(0, 32'h80000001);
        cmp(cmd_busy, 2'h0);
        $display("t_refuse done");
    endtask
    // a clearing read while the block is frozen must leave busy and the word alone
    task automatic t_freeze;
        start(1, 32'h3C5AA5C3, 0);
        finish(1);
        clock_en = 0;
        cpu_rd = 1;
        cpu_rd_link = 1;
        cpu_rd_index = 2'h3;
        repeat (2) @(negedge clock);
        cpu_rd = 0;
        clock_en = 1;
        @(negedge clock);
        cmp(cmd_busy, 2'h2);
        cmp(nirq[1], 2);
        rd_word(1, 32'h3C5AA5C3);
        cmp(cmd_busy, 2'h0);
        $display("t_freeze done");
    endtask
    task automatic t_hk;
        logic [31:0] exp [$];
        logic [31:0] w;
        logic ok;
        cpu_wr = 1;
        for (int n = 0; n < 20; n++) begin
            w = {8'hC0 + n[7:0], 16'h5A3C, n[7:0]};
            for (int i = 0; i < 4; i++) begin
                cpu_wr_index = i[1:0];
                cpu_wr_data = w[31-8*i -: 8];
                ok = hk_wr_ready;
                @(negedge clock);
            end
            if (ok)
                exp.push_back(w);
        end
        cpu_wr = 0;
        // one word per 4 cycles against one per 33 out: 16 fit, 3 leave, the last is refused
        cmp(exp.size(), 19);
        for (int k = 0; k < 1000 && rxq.size() < exp.size(); k++)
            @(negedge clock);
        cmp(rxq.size(), exp.size());
        foreach (exp[i])
            cmp(rxq[i], exp[i]);
        cmp(rxq1.size(), exp.size());
        foreach (exp[i])
            cmp(rxq1[i], exp[i]);
        $display("t_hk done");
    endtask
    initial begin
        repeat (20) @(negedge clock);
        rst = 0;
        repeat (2) @(negedge clock);
        t_rx();
        t_both();
        t_refuse();
        t_freeze();
        t_hk();
        close_out();
    end
endmodule
bind command_housekeeping_link_regs cmd_hk_checker u_cmd_hk_checker (.clock, .rst, .clock_en,
    .cmd_bit_valid, .cmd_busy, .irq_primary, .irq_secondary, .cpu_rd, .cpu_rd_link,
    .cpu_rd_index, .cpu_wr, .cpu_wr_index, .hk_wr_ready, .hk_tx_bit, .hk_tx_frame);
